/* File: hdl/slc_pkg.sv */
// Purpose: shared constants for the serial link control register bank
// Assumes: 32-bit AXI4-Lite, one aligned word per register
// Notes: byte address of a register is four times its index
package slc_pkg;
    // register indices, byte address = index * 4
    localparam logic [9:0] IDX_EN = 10'h200;
    localparam logic [9:0] IDX_MODE = 10'h201;
    localparam logic [9:0] IDX_FPM = 10'h202;
    localparam logic [9:0] IDX_SWSYNC = 10'h203;
    localparam logic [9:0] IDX_CTRL = 10'h204;
    localparam int ADDR_W = 12;
    // reset values
    localparam logic RST_EN = 1'h1;
    localparam logic [5:0] RST_MODE = 6'h00;
    localparam logic [7:0] RST_FPM = 8'h1f;
    localparam logic RST_SWSYNC = 1'h1;
    localparam logic [4:0] RST_CTRL = 5'h03;
    // link control field positions
    localparam int CTRL_SCR = 0;
    localparam int CTRL_SFMT = 1;
    localparam int CTRL_SEL_LO = 2;
    localparam int CTRL_ALT = 4;
    // sync source choices
    localparam logic [1:0] SEL_SYNCSE = 2'h0;
    localparam logic [1:0] SEL_TMSTP = 2'h1;
    localparam logic [1:0] SEL_NONE = 2'h2;
    // 64b/66b multiframe scale
    localparam logic [7:0] K66_SCALE_SHIFT = 8'h00;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : slc_pkg

/* File: hdl/slc_sync2.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module slc_sync2 #(
    parameter int W = 3
) (
    input wire logic clk_in, // system clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic [W-1:0] d_in, // raw pin levels
    output logic [W-1:0] q_out // synchronised levels
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } slc_sync_st_t;
    slc_sync_st_t s_r;
    slc_sync_st_t s_nxt;

    // shift through two stages
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.meta = d_in;
        s_nxt.stab = s_r.meta;
    end

    // pins idle high, so reset to high to avoid a false request
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            s_r <= '1;
        else
            s_r <= s_nxt;
    end

    assign q_out = s_r.stab;
endmodule : slc_sync2
`default_nettype wire

/* File: hdl/slc_mf_counter.sv */
// Purpose: multiframe clock counter, one count per frame clock
// Assumes: frame rate equals the system clock here
// Notes: held at zero while the link is disabled
`timescale 1ns/1ps
`default_nettype none
module slc_mf_counter #(
    parameter int CW = 16
) (
    input wire logic clk_in, // system clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic hold_in, // link disabled, keep in reset
    input wire logic realign_in, // sysref edge pulse
    input wire logic [CW-1:0] k_m1_in, // frames per multiframe minus one
    output logic [CW-1:0] count_out, // current frame in multiframe
    output logic boundary_out // pulse at multiframe start
);
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic bnd;
    } slc_mfc_st_t;
    slc_mfc_st_t s_r;
    slc_mfc_st_t s_nxt;

    // hold beats realign so sysref cannot move a disabled counter
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.bnd = 1'b0;
        if (hold_in)
            s_nxt.cnt = '0;
        else if (realign_in || s_r.cnt >= k_m1_in)
        begin
            s_nxt.cnt = '0;
            s_nxt.bnd = 1'b1;
        end
        else
            s_nxt.cnt = s_r.cnt + 1'b1;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign count_out = s_r.cnt;
    assign boundary_out = s_r.bnd;
endmodule : slc_mf_counter
`default_nettype wire

/* File: hdl/slc_top.sv */
// Purpose: serial link control registers behind an AXI4-Lite slave
// Assumes: mode table decode arrives from same-clock logic
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module slc_top
    import slc_pkg::*;
(
    input wire logic CLK_SYS_IN, // 50 MHz system clock
    input wire logic RESET_N_IN, // async reset, active low
    input wire logic [ADDR_W-1:0] AXI_AWADDR_IN, // write address
    input wire logic AXI_AWVALID_IN, // write address valid
    output logic AXI_AWREADY_OUT, // write address ready
    input wire logic [31:0] AXI_WDATA_IN, // write data
    input wire logic [3:0] AXI_WSTRB_IN, // write byte enables
    input wire logic AXI_WVALID_IN, // write data valid
    output logic AXI_WREADY_OUT, // write data ready
    output logic [1:0] AXI_BRESP_OUT, // write response
    output logic AXI_BVALID_OUT, // write response valid
    input wire logic AXI_BREADY_IN, // write response ready
    input wire logic [ADDR_W-1:0] AXI_ARADDR_IN, // read address
    input wire logic AXI_ARVALID_IN, // read address valid
    output logic AXI_ARREADY_OUT, // read address ready
    output logic [31:0] AXI_RDATA_OUT, // read data
    output logic [1:0] AXI_RRESP_OUT, // read response
    output logic AXI_RVALID_OUT, // read data valid
    input wire logic AXI_RREADY_IN, // read data ready
    input wire logic SYNCSE_N_IN, // single-ended sync pin, low requests
    input wire logic TMSTP_SYNC_N_IN, // timestamp pin used as sync, low requests
    input wire logic SYSREF_IN, // sysref pin, rising edge realigns
    input wire logic MODE_IS_64B66B_IN, // selected mode uses 64b/66b
    input wire logic [3:0] MODE_E_IN, // E of selected mode
    input wire logic [7:0] MODE_F_IN, // F of selected mode
    output logic LINK_ENABLE_OUT, // link enabled
    output logic LINK_RESET_N_OUT, // link logic reset, active low
    output logic SERDES_PD_OUT, // serializer power down
    output logic LINK_CLK_EN_OUT, // link clock gate enable
    output logic [5:0] MODE_OUT, // selected output mode
    output logic [15:0] K_M1_OUT, // effective frames per multiframe minus one
    output logic SYNC_REQ_OUT, // sync request, active high
    output logic ALT_LANES_OUT, // use upper lanes
    output logic SFORMAT_OUT, // 1 two's complement samples
    output logic SCRAMBLE_OUT, // 8b/10b scrambler on
    output logic [15:0] MF_COUNT_OUT, // multiframe counter value
    output logic MF_BOUNDARY_OUT // multiframe start pulse
);
    typedef struct packed {
        logic awready;
        logic aw_full;
        logic [9:0] aw_idx;
        logic wready;
        logic w_full;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic en;
        logic [5:0] mode;
        logic [7:0] fpm;
        logic swsync_n;
        logic [4:0] ctrl;
        logic sysref_d;
        logic sync_req;
        logic [15:0] k_m1;
    } slc_top_st_t;

    slc_top_st_t s_r;
    slc_top_st_t s_nxt;
    logic [2:0] pins_s;
    logic syncse_s;
    logic tmstp_s;
    logic sysref_s;
    logic wr_do;
    logic [9:0] wr_idx;
    logic [7:0] wr_val;
    logic [1:0] sel_nxt;

    // effective multiframe length minus one for 64b/66b modes
    function automatic logic [15:0] k66_m1(input logic [3:0] e, input logic [7:0] f);
        logic [19:0] q;
        q = {4'h0, e, K66_SCALE_SHIFT, 4'h0} >> 4;
        q = q / {12'h000, f};
        return q[15:0] - 16'h0001;
    endfunction : k66_m1

    // readback, reserved bits read zero, unmapped index flagged
    function automatic logic [8:0] reg_read(input slc_top_st_t st, input logic [9:0] idx);
        logic [8:0] r;
        r = {1'b1, 8'h00};
        case (idx)
            IDX_EN: r = {1'b0, 7'h00, st.en};
            IDX_MODE: r = {1'b0, 2'h0, st.mode};
            IDX_FPM: r = {1'b0, st.fpm};
            IDX_SWSYNC: r = {1'b0, 7'h00, st.swsync_n};
            IDX_CTRL: r = {1'b0, 3'h0, st.ctrl};
            default: r = {1'b1, 8'h00};
        endcase
        return r;
    endfunction : reg_read

    // sync, timestamp and sysref pins come from outside the clock domain
    slc_sync2 #(
        .W(3)
    ) u_sync (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(RESET_N_IN),
        .d_in({SYSREF_IN, TMSTP_SYNC_N_IN, SYNCSE_N_IN}),
        .q_out(pins_s)
    );
    assign syncse_s = pins_s[0];
    assign tmstp_s = pins_s[1];
    assign sysref_s = pins_s[2];

    // multiframe counter stays cleared whenever the link is off
    slc_mf_counter #(
        .CW(16)
    ) u_mfc (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(RESET_N_IN),
        .hold_in(!s_r.en),
        .realign_in(sysref_s && !s_r.sysref_d),
        .k_m1_in(s_r.k_m1),
        .count_out(MF_COUNT_OUT),
        .boundary_out(MF_BOUNDARY_OUT)
    );

    // bus slave and register next state
    always_comb
    begin
        logic [8:0] rd;
        rd = 9'h000;
        s_nxt = s_r;
        wr_do = 1'b0;
        wr_idx = 10'h000;
        wr_val = 8'h00;
        sel_nxt = 2'h0;
        s_nxt.sysref_d = sysref_s;
        // address and data are taken independently, in either order
        if (AXI_AWVALID_IN && s_r.awready)
        begin
            s_nxt.aw_full = 1'b1;
            s_nxt.aw_idx = AXI_AWADDR_IN[ADDR_W-1:2];
        end
        if (AXI_WVALID_IN && s_r.wready)
        begin
            s_nxt.w_full = 1'b1;
            s_nxt.w_data = AXI_WDATA_IN[7:0];
            s_nxt.w_lane0 = AXI_WSTRB_IN[0];
        end
        if (s_r.bvalid && AXI_BREADY_IN)
            s_nxt.bvalid = 1'b0;
        // one write at a time: commit only when no response is pending
        if (s_nxt.aw_full && s_nxt.w_full && !s_r.bvalid)
        begin
            rd = reg_read(s_r, s_nxt.aw_idx);
            wr_do = s_nxt.w_lane0 && !rd[8];
            wr_idx = s_nxt.aw_idx;
            wr_val = s_nxt.w_data;
            s_nxt.aw_full = 1'b0;
            s_nxt.w_full = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = rd[8] ? RESP_SLVERR : RESP_OKAY;
        end
        // reserved bits are dropped, so only defined fields store
        if (wr_do)
        begin
            case (wr_idx)
                IDX_EN: s_nxt.en = wr_val[0];
                IDX_MODE: s_nxt.mode = wr_val[5:0];
                IDX_FPM: s_nxt.fpm = wr_val;
                IDX_SWSYNC: s_nxt.swsync_n = wr_val[0];
                IDX_CTRL: s_nxt.ctrl = wr_val[4:0];
                default: s_nxt.en = s_r.en;
            endcase
        end
        s_nxt.awready = !s_nxt.aw_full;
        s_nxt.wready = !s_nxt.w_full;
        // read: address refused while a read answer is outstanding
        if (s_r.rvalid && AXI_RREADY_IN)
        begin
            s_nxt.rvalid = 1'b0;
            s_nxt.arready = 1'b1;
        end
        if (AXI_ARVALID_IN && s_r.arready)
        begin
            rd = reg_read(s_r, AXI_ARADDR_IN[ADDR_W-1:2]);
            s_nxt.rvalid = 1'b1;
            s_nxt.arready = 1'b0;
            s_nxt.rdata = rd[7:0];
            s_nxt.rresp = rd[8] ? RESP_SLVERR : RESP_OKAY;
        end
        // effective length follows a register write on the same edge that stores it
        if (MODE_IS_64B66B_IN && MODE_F_IN != 8'h00)
            s_nxt.k_m1 = k66_m1(MODE_E_IN, MODE_F_IN);
        else
            s_nxt.k_m1 = {8'h00, s_nxt.fpm};
        // software bit works under any source; pins only for choices 0 and 1
        sel_nxt = s_nxt.ctrl[CTRL_SEL_LO+1:CTRL_SEL_LO];
        s_nxt.sync_req = !s_nxt.swsync_n;
        if (sel_nxt == SEL_SYNCSE && !syncse_s)
            s_nxt.sync_req = 1'b1;
        if (sel_nxt == SEL_TMSTP && !tmstp_s)
            s_nxt.sync_req = 1'b1;
    end

    // state register, defaults on reset
    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            s_r <= '0;
            s_r.awready <= 1'b1;
            s_r.wready <= 1'b1;
            s_r.arready <= 1'b1;
            s_r.en <= RST_EN;
            s_r.mode <= RST_MODE;
            s_r.fpm <= RST_FPM;
            s_r.swsync_n <= RST_SWSYNC;
            s_r.ctrl <= RST_CTRL;
            s_r.k_m1 <= {8'h00, RST_FPM};
            // synchroniser resets high, so match it or release shows a false sysref edge
            s_r.sysref_d <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    // outputs straight from the state flops
    assign AXI_AWREADY_OUT = s_r.awready;
    assign AXI_WREADY_OUT = s_r.wready;
    assign AXI_BVALID_OUT = s_r.bvalid;
    assign AXI_BRESP_OUT = s_r.bresp;
    assign AXI_ARREADY_OUT = s_r.arready;
    assign AXI_RVALID_OUT = s_r.rvalid;
    assign AXI_RRESP_OUT = s_r.rresp;
    assign AXI_RDATA_OUT = {24'h000000, s_r.rdata};
    assign LINK_ENABLE_OUT = s_r.en;
    // link off keeps the whole link in reset and saves power
    assign LINK_RESET_N_OUT = s_r.en;
    assign SERDES_PD_OUT = !s_r.en;
    assign LINK_CLK_EN_OUT = s_r.en;
    assign MODE_OUT = s_r.mode;
    assign K_M1_OUT = s_r.k_m1;
    assign SYNC_REQ_OUT = s_r.sync_req;
    assign ALT_LANES_OUT = s_r.ctrl[CTRL_ALT];
    assign SFORMAT_OUT = s_r.ctrl[CTRL_SFMT];
    assign SCRAMBLE_OUT = s_r.ctrl[CTRL_SCR];

    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!RESET_N_IN);

    // disabled link shows all three side effects at once
    property p_link_off;
        !LINK_ENABLE_OUT |-> !LINK_RESET_N_OUT && SERDES_PD_OUT && !LINK_CLK_EN_OUT;
    endproperty
    a_link_off: assert property (p_link_off)
        else $error("link off without reset, power down and clock gate");

    // enable bit follows a committed write of bit 0
    property p_en_write;
        wr_do && wr_idx == IDX_EN |=> LINK_ENABLE_OUT == $past(wr_val[0]);
    endproperty
    a_en_write: assert property (p_en_write)
        else $error("link enable did not take written value");

    // counter reaches and stays at zero while disabled
    property p_mf_hold;
        !LINK_ENABLE_OUT ##1 !LINK_ENABLE_OUT |-> MF_COUNT_OUT == 16'h0000;
    endproperty
    a_mf_hold: assert property (p_mf_hold)
        else $error("multiframe counter moved while link off");

    // sysref must not mark a multiframe start while the link is off
    property p_bnd_off;
        !LINK_ENABLE_OUT ##1 !LINK_ENABLE_OUT |-> !MF_BOUNDARY_OUT;
    endproperty
    a_bnd_off: assert property (p_bnd_off)
        else $error("multiframe boundary while link off");

    property p_mode_write;
        wr_do && wr_idx == IDX_MODE |=> MODE_OUT == $past(wr_val[5:0]);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("mode field did not take written value");

    property p_k_reg;
        !MODE_IS_64B66B_IN |=> K_M1_OUT == {8'h00, s_r.fpm};
    endproperty
    a_k_reg: assert property (p_k_reg)
        else $error("effective length differs from register");

    property p_k66;
        MODE_IS_64B66B_IN && MODE_F_IN == 8'h02 && MODE_E_IN == 4'h1
            |=> K_M1_OUT == 16'h007f;
    endproperty
    a_k66: assert property (p_k66)
        else $error("64b/66b length not 256*E/F");

    property p_sw_sync;
        !s_r.swsync_n |-> SYNC_REQ_OUT;
    endproperty
    a_sw_sync: assert property (p_sw_sync)
        else $error("software sync bit did not raise request");

    property p_pin_low;
        s_r.ctrl[3:2] == SEL_SYNCSE && !$past(syncse_s) |-> SYNC_REQ_OUT;
    endproperty
    a_pin_low: assert property (p_pin_low)
        else $error("low sync pin did not hold request");

    // timestamp pin, when selected, holds the request the same way
    property p_tmstp_low;
        s_r.ctrl[3:2] == SEL_TMSTP && !$past(tmstp_s) |-> SYNC_REQ_OUT;
    endproperty
    a_tmstp_low: assert property (p_tmstp_low)
        else $error("low timestamp sync pin did not hold request");

    property p_no_pin;
        s_r.ctrl[3:2] == SEL_NONE |-> SYNC_REQ_OUT == !s_r.swsync_n;
    endproperty
    a_no_pin: assert property (p_no_pin)
        else $error("pins not ignored under source choice 2");

    property p_bhold;
        AXI_BVALID_OUT && !AXI_BREADY_IN |=> AXI_BVALID_OUT && $stable(AXI_BRESP_OUT);
    endproperty
    a_bhold: assert property (p_bhold)
        else $error("write response dropped before taken");
endmodule : slc_top
`default_nettype wire

/* File: testbench/testbench.sv */
// Purpose: self-checking bench for the serial link control register bank
// Assumes: AXI4-Lite master with at most one write and one read in flight
// Notes: expected bus answers are queued by the drivers and compared by a monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import slc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'h1;
    logic syncse_n = 1'b1;
    logic tmstp_n = 1'b1;
    logic sysref = 1'b0;
    logic mode_64 = 1'b0;
    logic [3:0] mode_e = 4'h1;
    logic [7:0] mode_f = 8'h1;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic link_en, link_rst_n, serdes_pd, link_clk_en, sync_req, alt, sfmt, scr, mf_bnd;
    logic [5:0] mode;
    logic [15:0] k_m1, mf_cnt;
    logic [33:0] rd_q[$];
    logic [1:0] b_q[$];
    int mismatches = 0;
    int n_tests = 0;
    integer seed = 32'h56d2;

    slc_top u_dut (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n),
        .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid), .AXI_AWREADY_OUT(awready),
        .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(wstrb), .AXI_WVALID_IN(wvalid),
        .AXI_WREADY_OUT(wready), .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid),
        .AXI_BREADY_IN(bready), .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid),
        .AXI_ARREADY_OUT(arready), .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp),
        .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready), .SYNCSE_N_IN(syncse_n),
        .TMSTP_SYNC_N_IN(tmstp_n), .SYSREF_IN(sysref), .MODE_IS_64B66B_IN(mode_64),
        .MODE_E_IN(mode_e), .MODE_F_IN(mode_f), .LINK_ENABLE_OUT(link_en),
        .LINK_RESET_N_OUT(link_rst_n), .SERDES_PD_OUT(serdes_pd),
        .LINK_CLK_EN_OUT(link_clk_en), .MODE_OUT(mode), .K_M1_OUT(k_m1),
        .SYNC_REQ_OUT(sync_req), .ALT_LANES_OUT(alt), .SFORMAT_OUT(sfmt),
        .SCRAMBLE_OUT(scr), .MF_COUNT_OUT(mf_cnt), .MF_BOUNDARY_OUT(mf_bnd));

    // free-running 50 MHz clock
    initial
    begin
        forever #10 clk = ~clk;
    end

    task automatic summarize;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, mismatches);
            if (mismatches == 0 && n_tests > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask : summarize

    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        begin
            n_tests++;
            if (seen !== exp)
            begin
                mismatches++;
                $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask : check

    // a wait that ran out of its bound ends the run at once
    task automatic give_up;
        begin
            mismatches++;
            summarize();
        end
    endtask : give_up

    // let n edges pass, then step off the edge so outputs are settled
    task automatic tick(input int n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask : tick

    // bytes above lane 0 carry random junk; only the low byte comes from the caller
    task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
        int n;
        logic [23:0] junk;
        begin
            n = 0;
            junk = 24'($random(seed));
            @(posedge clk);
            awaddr <= {idx, 2'b00};
            wdata <= {junk, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            b_q.push_back(er);
            do
            begin
                @(posedge clk);
                n++;
                if (awvalid && awready)
                    awvalid <= 1'b0;
                if (wvalid && wready)
                    wvalid <= 1'b0;
            end
            while (!(bvalid && bready) && n < 100);
            bready <= 1'b0;
            if (n >= 100)
                give_up();
            #1;
        end
    endtask : wr

    task automatic rd(input logic [9:0] idx, input logic [33:0] exp);
        int n;
        begin
            n = 0;
            @(posedge clk);
            araddr <= {idx, 2'b00};
            arvalid <= 1'b1;
            rready <= 1'b1;
            rd_q.push_back(exp);
            do
            begin
                @(posedge clk);
                n++;
                if (arvalid && arready)
                    arvalid <= 1'b0;
            end
            while (!(rvalid && rready) && n < 100);
            rready <= 1'b0;
            if (n >= 100)
                give_up();
            #1;
        end
    endtask : rd

    // monitor: each bus answer is matched to the oldest queued expectation
    always @(posedge clk)
    begin
        if (rvalid && rready)
            check("read", {rresp, rdata}, (rd_q.size() > 0) ? rd_q.pop_front() : 34'h0);
        if (bvalid && bready)
            check("bresp", 34'(bresp), (b_q.size() > 0) ? 34'(b_q.pop_front()) : 34'h3);
    end

    initial
    begin : main
        logic [7:0] v;
        int e, f, prev;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        tick(3);
        check("link ports", 34'({link_en, link_rst_n, serdes_pd, link_clk_en}), 34'h0d);
        check("k_m1", 34'(k_m1), 34'h1f);
        // reset values and an unmapped word
        rd(IDX_EN, {RESP_OKAY, 32'h01});
        rd(IDX_MODE, {RESP_OKAY, 32'h00});
        rd(IDX_FPM, {RESP_OKAY, 32'h1f});
        rd(IDX_SWSYNC, {RESP_OKAY, 32'h01});
        rd(IDX_CTRL, {RESP_OKAY, 32'h03});
        rd(10'h205, {RESP_SLVERR, 32'h0});
        wr(10'h205, 8'h55, RESP_SLVERR);
        // link off before any other edit; side effects and a held counter
        wr(IDX_EN, 8'h00, RESP_OKAY);
        check("link off", 34'({link_en, link_rst_n, serdes_pd, link_clk_en}), 34'h02);
        @(posedge clk);
        sysref <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            tick(1);
            check("held counter", 34'(mf_cnt), 34'h0);
        end
        @(posedge clk);
        sysref <= 1'b0;
        // output mode, extremes then a random value
        for (int i = 0; i < 3; i++)
        begin
            v = (i == 0) ? 8'h3f : (i == 1) ? 8'h00 : {2'b00, 6'($random(seed))};
            wr(IDX_MODE, v, RESP_OKAY);
            check("mode", 34'(mode), 34'(v));
            rd(IDX_MODE, {RESP_OKAY, 24'h0, v});
        end
        // multiframe length, from the register and from E and F
        v = 8'($random(seed));
        wr(IDX_FPM, v, RESP_OKAY);
        rd(IDX_FPM, {RESP_OKAY, 24'h0, v});
        check("k_m1 reg", 34'(k_m1), 34'(v));
        for (int i = 0; i < 5; i++)
        begin
            e = (i == 0) ? 1 : (i == 1) ? 15 : (i == 2) ? 4 : ($random(seed) & 15) | 1;
            f = (i == 0) ? 2 : (i == 1) ? 1 : (i == 2) ? 8 : ($random(seed) & 255) | 1;
            @(posedge clk);
            mode_64 <= 1'b1;
            mode_e <= 4'(e);
            mode_f <= 8'(f);
            tick(3);
            check("k_m1 66b", 34'(k_m1), 34'(256 * e / f - 1));
        end
        @(posedge clk);
        mode_64 <= 1'b0;
        tick(3);
        check("k_m1 back", 34'(k_m1), 34'(v));
        // sync request under every source choice, with no pin, the sync pin or the timestamp pin low
        for (int s = 0; s < 4; s++)
        begin
            wr(IDX_CTRL, {4'h0, 2'(s), 2'b11}, RESP_OKAY);
            for (int p = 0; p < 4; p++)
            begin
                @(posedge clk);
                syncse_n <= (p != 1);
                tmstp_n <= (p != 2);
                tick(4);
                check("sync pin", 34'(sync_req), 34'((p == 1 && s == 0) || (p == 2 && s == 1)));
            end
            wr(IDX_SWSYNC, 8'h00, RESP_OKAY);
            check("sync soft", 34'(sync_req), 34'h1);
            wr(IDX_SWSYNC, 8'h01, RESP_OKAY);
            check("sync idle", 34'(sync_req), 34'h0);
        end
        wr(IDX_CTRL, 8'h10, RESP_OKAY);
        check("ctrl bits", 34'({alt, sfmt, scr}), 34'h4);
        rd(IDX_CTRL, {RESP_OKAY, 32'h10});
        // a write with byte lane 0 off answers okay and stores nothing
        @(posedge clk);
        wstrb <= 4'h0;
        wr(IDX_CTRL, 8'h01, RESP_OKAY);
        @(posedge clk);
        wstrb <= 4'h1;
        rd(IDX_CTRL, {RESP_OKAY, 32'h10});
        // short multiframe, then enable and step the counter
        wr(IDX_FPM, 8'h03, RESP_OKAY);
        wr(IDX_EN, 8'h01, RESP_OKAY);
        check("link on", 34'({link_en, link_rst_n, serdes_pd, link_clk_en}), 34'h0d);
        tick(2);
        for (int i = 0; i < 12; i++)
        begin
            prev = int'(mf_cnt);
            tick(1);
            check("count step", 34'(mf_cnt), 34'((prev == 3) ? 0 : prev + 1));
            check("boundary", 34'(mf_bnd), 34'(mf_cnt == 16'h0000));
        end
        // a sysref rising edge while enabled restarts the multiframe early
        @(posedge clk);
        sysref <= 1'b1;
        tick(3);
        check("realign", 34'({mf_bnd, mf_cnt}), 34'h10000);
        @(posedge clk);
        sysref <= 1'b0;
        wr(IDX_EN, 8'h00, RESP_OKAY);
        tick(2);
        check("count off", 34'(mf_cnt), 34'h0);
        summarize();
    end
endmodule : testbench
`default_nettype wire
